// [design/vcc_codec_control.sv]
`timescale 1ns/10ps
// Contract
// - reset: sidetone, filters off, gains 0 dB, mu-law
// - path registers cleared, codec powered down
// - one 8-bit word per sample each direction
// - law and coding bits select both directions
// - sign-magnitude code assignment
// - mu-law inverted magnitude code assignment
// - A-law alternate digit inversion
// - transmit high-pass enable bit
// - dial-tone low-pass enable bit
// - sidetone tapped before transmit gain
// - sidetone summed after receive gain
// - sidetone enable bit switches path
// - transmit gain 0 to +7 dB
// - receive gain 0 to -7 dB
// - sidetone gain -9.96 to +13.28 dB
// - transmit offset nulled within one step
module vcc_codec_control #(
   parameter int LIN_W = 16
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic tx_lin_valid,
   input wire logic signed [LIN_W-1:0] tx_lin,
   output logic tx_pcm_valid,
   output logic [7:0] tx_pcm,
   input wire logic rx_pcm_valid,
   input wire logic [7:0] rx_pcm,
   output logic rx_lin_valid,
   output logic signed [LIN_W-1:0] rx_lin,
   input wire logic signed [LIN_W-1:0] rx_gained,
   output logic signed [LIN_W-1:0] handset_drive,
   output logic tx_powered,
   output logic rx_powered,
   output logic tx_hpf_en,
   output logic dial_lpf_en,
   output logic sidetone_en,
   output logic [2:0] tx_filter_gain,
   output logic [2:0] rx_filter_gain,
   output logic [2:0] sidetone_gain_code,
   output logic signed [11:0] tx_gain_cdb,
   output logic signed [11:0] rx_gain_cdb,
   output logic signed [11:0] st_gain_cdb
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] gain;
      logic [7:0] stg;
      logic [7:0] opt;
      logic [7:0] law;
      logic [7:0] txp;
      logic [7:0] rxp;
      logic [7:0] rdata;
      logic tx_v;
      logic [7:0] tx_pcm;
      logic rx_v;
      logic signed [LIN_W-1:0] rx_lin;
      logic signed [LIN_W-1:0] hs;
      logic signed [LIN_W-1:0] ofs;
   } vcc_state_t;

   vcc_state_t st_r;
   vcc_state_t st_nxt;

   // ------------------------------------------------------------
   // code functions
   // ------------------------------------------------------------
   // 12-bit magnitude segmented into chord and step
   function automatic logic [7:0] vcc_lin_to_sm(
      input logic signed [LIN_W-1:0] x
   );
      logic neg;
      logic [LIN_W-1:0] mag;
      logic [11:0] m;
      logic [2:0] ch;
      logic [3:0] stp;
      neg = x[LIN_W-1];
      mag = neg ? LIN_W'(-x) : LIN_W'(x);
      // most negative value saturates to full scale
      if (mag[LIN_W-1])
         mag = {1'b0, {(LIN_W-1){1'b1}}};
      m = mag[LIN_W-2 -: 12];
      ch = 3'd0;
      stp = m[4:1];
      for (int i = 1; i < 8; i++)
      begin
         if (m[i+4])
         begin
            ch = 3'(i);
            stp = m[i+3 -: 4];
         end
      end
      return {~neg, ch, stp};
   endfunction : vcc_lin_to_sm

   function automatic logic signed [LIN_W-1:0] vcc_sm_to_lin(
      input logic [7:0] c
   );
      logic [11:0] m;
      logic [LIN_W-1:0] mag;
      if (c[6:4] == 3'd0)
         m = {7'd0, c[3:0], 1'b1};
      else
         m = 12'({6'd0, 1'b1, c[3:0], 1'b1} << (c[6:4] - 3'd1));
      mag = {1'b0, m, {(LIN_W-13){1'b0}}};
      return c[7] ? $signed(mag) : $signed(LIN_W'(-mag));
   endfunction : vcc_sm_to_lin

   // sign-magnitude to line code, and back (both are self-inverse)
   function automatic logic [7:0] vcc_fmt(
      input logic [7:0] sm,
      input logic [7:0] lawreg
   );
      if (lawreg[vcc_pkg::CODING_SCHEME_BIT])
         return sm;
      else if (lawreg[vcc_pkg::LAW_ALAW_BIT])
         return sm ^ vcc_pkg::ALAW_INVERT_MASK;
      else
         return {sm[7], sm[6:0] ^ vcc_pkg::MULAW_MAG_MASK};
   endfunction : vcc_fmt

   function automatic logic signed [11:0] vcc_gain(
      input logic [2:0] code,
      input logic signed [11:0] base,
      input logic signed [11:0] step
   );
      return 12'(base + $signed({9'd0, code}) * step);
   endfunction : vcc_gain

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic signed [LIN_W-1:0] tx_corr;
   logic [7:0] tx_sm;
   logic st_on;

   always_comb
   begin
      st_nxt = st_r;
      st_on = st_r.rxp[vcc_pkg::SIDETONE_EN_BIT];
      // offset estimate follows the mean one linear LSB at a time
      tx_corr = LIN_W'(tx_lin - st_r.ofs);
      tx_sm = vcc_lin_to_sm(tx_corr);

      if (reg_wr)
      begin
         case (reg_addr)
            vcc_pkg::OFS_CODEC_FILTER_GAIN: st_nxt.gain = reg_wdata;
            vcc_pkg::OFS_SIDETONE_GAIN: st_nxt.stg = reg_wdata;
            vcc_pkg::OFS_FILTER_OPTION_CONTROL: st_nxt.opt = reg_wdata;
            vcc_pkg::OFS_CODING_LAW_CONTROL: st_nxt.law = reg_wdata;
            vcc_pkg::OFS_TRANSMIT_PATH_CONTROL: st_nxt.txp = reg_wdata;
            vcc_pkg::OFS_RECEIVE_PATH_CONTROL: st_nxt.rxp = reg_wdata;
            default: st_nxt.gain = st_r.gain;
         endcase
      end

      if (reg_rd)
      begin
         case (reg_addr)
            vcc_pkg::OFS_CODEC_FILTER_GAIN: st_nxt.rdata = st_r.gain;
            vcc_pkg::OFS_SIDETONE_GAIN: st_nxt.rdata = st_r.stg;
            vcc_pkg::OFS_FILTER_OPTION_CONTROL: st_nxt.rdata = st_r.opt;
            vcc_pkg::OFS_CODING_LAW_CONTROL: st_nxt.rdata = st_r.law;
            vcc_pkg::OFS_TRANSMIT_PATH_CONTROL: st_nxt.rdata = st_r.txp;
            vcc_pkg::OFS_RECEIVE_PATH_CONTROL: st_nxt.rdata = st_r.rxp;
            default: st_nxt.rdata = vcc_pkg::RDATA_UNMAPPED;
         endcase
      end

      // powered-down paths produce no words
      st_nxt.tx_v = tx_lin_valid && (st_r.txp != 8'h00);
      st_nxt.rx_v = rx_pcm_valid && (st_r.rxp != 8'h00);

      if (tx_lin_valid && (st_r.txp != 8'h00))
      begin
         st_nxt.tx_pcm = vcc_fmt(tx_sm, st_r.law);
         if (tx_corr > 0)
            st_nxt.ofs = LIN_W'(st_r.ofs + 1);
         else if (tx_corr < 0)
            st_nxt.ofs = LIN_W'(st_r.ofs - 1);
      end

      if (rx_pcm_valid && (st_r.rxp != 8'h00))
         st_nxt.rx_lin = vcc_sm_to_lin(vcc_fmt(rx_pcm, st_r.law));

      // tap is the raw transmit sample, ahead of transmit gain;
      // sum is after receive gain, so neither gain touches it
      st_nxt.hs = st_on ? LIN_W'(rx_gained + tx_lin)
                        : rx_gained;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '0;
         st_r.gain <= vcc_pkg::RST_CODEC_FILTER_GAIN;
         st_r.stg <= vcc_pkg::RST_SIDETONE_GAIN;
         st_r.opt <= vcc_pkg::RST_FILTER_OPTION_CONTROL;
         st_r.law <= vcc_pkg::RST_CODING_LAW_CONTROL;
         st_r.txp <= vcc_pkg::RST_PATH_CONTROL;
         st_r.rxp <= vcc_pkg::RST_PATH_CONTROL;
      end
      else
         st_r <= st_nxt;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata = st_r.rdata;
   assign tx_pcm_valid = st_r.tx_v;
   assign tx_pcm = st_r.tx_pcm;
   assign rx_lin_valid = st_r.rx_v;
   assign rx_lin = st_r.rx_lin;
   assign handset_drive = st_r.hs;
   assign tx_powered = st_r.txp != 8'h00;
   assign rx_powered = st_r.rxp != 8'h00;
   assign tx_hpf_en = st_r.opt[vcc_pkg::TX_HPF_BIT];
   assign dial_lpf_en = st_r.opt[vcc_pkg::DIAL_LPF_BIT];
   assign sidetone_en = st_r.rxp[vcc_pkg::SIDETONE_EN_BIT];
   assign tx_filter_gain = st_r.gain[vcc_pkg::TX_GAIN_LSB +: 3];
   assign rx_filter_gain = st_r.gain[vcc_pkg::RX_GAIN_LSB +: 3];
   assign sidetone_gain_code = st_r.stg[vcc_pkg::ST_GAIN_LSB +: 3];
   assign tx_gain_cdb = vcc_gain(tx_filter_gain, 12'sd0,
      vcc_pkg::TX_GAIN_STEP_CDB);
   assign rx_gain_cdb = vcc_gain(rx_filter_gain, 12'sd0,
      vcc_pkg::RX_GAIN_STEP_CDB);
   assign st_gain_cdb = vcc_gain(sidetone_gain_code,
      vcc_pkg::ST_GAIN_MIN_CDB, vcc_pkg::ST_GAIN_STEP_CDB);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   logic first_r;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         first_r <= 1'b1;
      else
         first_r <= 1'b0;
   end

   a_reset_defaults: assert property (
      first_r |-> !sidetone_en && !tx_hpf_en && !dial_lpf_en
      && tx_gain_cdb == 0 && rx_gain_cdb == 0 && st_gain_cdb == 0
      && st_r.law == 8'h00)
      else $error("reset defaults wrong");
   a_reset_powerdown: assert property (
      first_r |-> !tx_powered && !rx_powered)
      else $error("path powered after reset");
   a_tx_powerdown: assert property (
      tx_pcm_valid |-> $past(tx_powered) && $past(tx_lin_valid))
      else $error("word from powered-down transmit path");
   a_tx_word_timing: assert property (
      tx_lin_valid && tx_powered |=> tx_pcm_valid)
      else $error("transmit word missing");
   a_rx_powerdown: assert property (
      rx_lin_valid |-> $past(rx_powered) && $past(rx_pcm_valid))
      else $error("word from powered-down receive path");
   a_rx_word_timing: assert property (
      rx_pcm_valid && rx_powered |=> rx_lin_valid)
      else $error("receive word missing");
   a_tx_pcm_hold: assert property (
      !tx_pcm_valid |-> $stable(tx_pcm))
      else $error("transmit word changed without a sample");
   a_rx_lin_hold: assert property (
      !rx_lin_valid |-> $stable(rx_lin))
      else $error("receive sample changed without a word");
   a_alaw_invert: assert property (
      tx_lin_valid && tx_powered && st_r.law == 8'h02
      |=> tx_pcm == ($past(tx_sm) ^ 8'h55))
      else $error("A-law inversion wrong");
   a_mulaw_invert: assert property (
      tx_lin_valid && tx_powered && st_r.law == 8'h00
      |=> tx_pcm == {$past(tx_sm[7]), ~$past(tx_sm[6:0])})
      else $error("mu-law inversion wrong");
   a_signmag_plain: assert property (
      tx_lin_valid && tx_powered && st_r.law[0]
      |=> tx_pcm == $past(tx_sm))
      else $error("sign-magnitude code wrong");
   a_rx_sign: assert property (
      rx_pcm_valid && rx_powered
      |=> rx_lin[LIN_W-1] == !$past(rx_pcm[7]))
      else $error("receive sign wrong");
   a_gain_write: assert property (
      reg_wr && reg_addr == vcc_pkg::OFS_CODEC_FILTER_GAIN
      |=> tx_filter_gain == $past(reg_wdata[6:4])
      && rx_filter_gain == $past(reg_wdata[2:0]))
      else $error("filter gain field not written");
   a_stg_write: assert property (
      reg_wr && reg_addr == vcc_pkg::OFS_SIDETONE_GAIN
      |=> sidetone_gain_code == $past(reg_wdata[2:0]))
      else $error("sidetone gain field not written");
   a_tx_gain_map: assert property (
      tx_gain_cdb == 12'($signed({9'd0, tx_filter_gain}) * 100))
      else $error("transmit gain map wrong");
   a_rx_gain_map: assert property (
      rx_gain_cdb == 12'(-$signed({9'd0, rx_filter_gain}) * 100))
      else $error("receive gain map wrong");
   a_st_gain_map: assert property (
      st_gain_cdb == 12'(332 * int'(sidetone_gain_code) - 996))
      else $error("sidetone gain map wrong");
   a_sidetone_write: assert property (
      reg_wr && reg_addr == vcc_pkg::OFS_RECEIVE_PATH_CONTROL
      |=> sidetone_en == $past(reg_wdata[0]))
      else $error("sidetone enable not written");
   a_sidetone_off: assert property (
      !sidetone_en |=> handset_drive == $past(rx_gained))
      else $error("sidetone leaks while off");
   a_sidetone_on: assert property (
      sidetone_en
      |=> handset_drive == LIN_W'($past(rx_gained) + $past(tx_lin)))
      else $error("sidetone sum wrong");
   a_hpf_write: assert property (
      reg_wr && reg_addr == vcc_pkg::OFS_FILTER_OPTION_CONTROL
      |=> tx_hpf_en == $past(reg_wdata[0]))
      else $error("high-pass enable not written");
   a_dial_write: assert property (
      reg_wr && reg_addr == vcc_pkg::OFS_FILTER_OPTION_CONTROL
      |=> dial_lpf_en == $past(reg_wdata[1]))
      else $error("dial-tone enable not written");
   a_path_write: assert property (
      reg_wr && reg_addr == vcc_pkg::OFS_TRANSMIT_PATH_CONTROL
      |=> tx_powered == ($past(reg_wdata) != 8'h00))
      else $error("transmit power state not written");
   a_ofs_step: assert property (
      tx_lin_valid && tx_powered
      |=> st_r.ofs - $past(st_r.ofs) inside {-1, 0, 1})
      else $error("offset estimate jumped");

   c_tx_word: cover property (tx_lin_valid && tx_powered ##1 tx_pcm_valid);
   c_rx_word: cover property (rx_pcm_valid && rx_powered ##1 rx_lin_valid);
   c_alaw_sel: cover property (st_r.law == 8'h02 && tx_pcm_valid);
   c_signmag_sel: cover property (st_r.law[0] && tx_pcm_valid);
   c_sidetone_on: cover property (sidetone_en && rx_gained != 0);

endmodule : vcc_codec_control

// [shared/vcc_pkg.sv]
package vcc_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CODEC_FILTER_GAIN = 8'h0A;
   localparam logic [7:0] OFS_SIDETONE_GAIN = 8'h0B;
   localparam logic [7:0] OFS_FILTER_OPTION_CONTROL = 8'h0E;
   localparam logic [7:0] OFS_CODING_LAW_CONTROL = 8'h0F;
   localparam logic [7:0] OFS_TRANSMIT_PATH_CONTROL = 8'h12;
   localparam logic [7:0] OFS_RECEIVE_PATH_CONTROL = 8'h13;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int RX_GAIN_LSB = 0;
   localparam int TX_GAIN_LSB = 4;
   localparam int ST_GAIN_LSB = 0;
   localparam int TX_HPF_BIT = 0;
   localparam int DIAL_LPF_BIT = 1;
   localparam int CODING_SCHEME_BIT = 0;
   localparam int LAW_ALAW_BIT = 1;
   localparam int SIDETONE_EN_BIT = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_CODEC_FILTER_GAIN = 8'h00;
   // code 3 is the 0 dB step of the sidetone gain scale
   localparam logic [7:0] RST_SIDETONE_GAIN = 8'h03;
   localparam logic [7:0] RST_FILTER_OPTION_CONTROL = 8'h00;
   localparam logic [7:0] RST_CODING_LAW_CONTROL = 8'h00;
   localparam logic [7:0] RST_PATH_CONTROL = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // ------------------------------------------------------------
   // code format constants
   // ------------------------------------------------------------
   localparam logic [7:0] ALAW_INVERT_MASK = 8'h55;
   localparam logic [6:0] MULAW_MAG_MASK = 7'h7F;

   // ------------------------------------------------------------
   // gain steps, in hundredths of a dB
   // ------------------------------------------------------------
   localparam logic signed [11:0] TX_GAIN_STEP_CDB = 12'sd100;
   localparam logic signed [11:0] RX_GAIN_STEP_CDB = -12'sd100;
   localparam logic signed [11:0] ST_GAIN_STEP_CDB = 12'sd332;
   localparam logic signed [11:0] ST_GAIN_MIN_CDB = -12'sd996;

endpackage : vcc_pkg

// [verif/vcc_pcm_source.sv]
`timescale 1ns/10ps
// far-side pcm port: one word per request, scrambled line between words
module vcc_pcm_source (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic send_req,
   input wire logic [7:0] send_word,
   output logic rx_pcm_valid,
   output logic [7:0] rx_pcm
);
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_pcm_valid <= 1'b0;
         rx_pcm <= 8'hA5;
      end
      else if (send_req)
      begin
         rx_pcm_valid <= 1'b1;
         rx_pcm <= send_word;
      end
      else
      begin
         // stale word must never look valid
         rx_pcm_valid <= 1'b0;
         rx_pcm <= ~rx_pcm;
      end
   end
endmodule : vcc_pcm_source

// [verif/vcc_codec_control_test.sv]
`timescale 1ns/10ps
module vcc_codec_control_test;
   logic sys_clk, arst_n, reg_wr, reg_rd, tx_lin_valid, send_req;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_pcm, rx_pcm, send_word;
   logic signed [15:0] tx_lin, rx_lin, rx_gained, handset_drive;
   logic tx_pcm_valid, rx_pcm_valid, rx_lin_valid, tx_powered, rx_powered;
   logic tx_hpf_en, dial_lpf_en, sidetone_en;
   logic [2:0] tx_filter_gain, rx_filter_gain, sidetone_gain_code;
   logic signed [11:0] tx_gain_cdb, rx_gain_cdb, st_gain_cdb;
   int errors, comparisons;
   logic [7:0] ofs [6] = '{8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h12, 8'h13};
   // sidetone gain resets to its 0 dB step
   logic [7:0] rst_val [6] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] lawreg [3] = '{8'h01, 8'h00, 8'h02};
   logic [7:0] codes [3][4] = '{'{8'hFF, 8'h80, 8'h00, 8'h7F},
      '{8'h80, 8'hFF, 8'h7F, 8'h00}, '{8'hAA, 8'hD5, 8'h55, 8'h2A}};
   logic signed [15:0] smp [4] = '{16'sh7FFF, 16'sh0006, -16'sh0006,
      -16'sh7FFF};

   vcc_codec_control i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .tx_lin_valid(tx_lin_valid), .tx_lin(tx_lin),
      .tx_pcm_valid(tx_pcm_valid), .tx_pcm(tx_pcm),
      .rx_pcm_valid(rx_pcm_valid), .rx_pcm(rx_pcm),
      .rx_lin_valid(rx_lin_valid), .rx_lin(rx_lin), .rx_gained(rx_gained),
      .handset_drive(handset_drive), .tx_powered(tx_powered),
      .rx_powered(rx_powered), .tx_hpf_en(tx_hpf_en),
      .dial_lpf_en(dial_lpf_en), .sidetone_en(sidetone_en),
      .tx_filter_gain(tx_filter_gain), .rx_filter_gain(rx_filter_gain),
      .sidetone_gain_code(sidetone_gain_code), .tx_gain_cdb(tx_gain_cdb),
      .rx_gain_cdb(rx_gain_cdb), .st_gain_cdb(st_gain_cdb));

   vcc_pcm_source i_src (.sys_clk(sys_clk), .arst_n(arst_n),
      .send_req(send_req), .send_word(send_word),
      .rx_pcm_valid(rx_pcm_valid), .rx_pcm(rx_pcm));

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic signed [15:0] e,
      input logic signed [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
      end
   endtask : check

   task automatic check_defaults();
      check("st_gain_cdb", 0, st_gain_cdb);
      check("flags", 0, {tx_hpf_en, dial_lpf_en, sidetone_en});
      check("gains", 0, tx_gain_cdb | rx_gain_cdb);
      check("powered", 0, {tx_powered, rx_powered});
   endtask : check_defaults

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", e, reg_rdata);
   endtask : rd

   task automatic tx(input logic signed [15:0] s, input logic v,
      input logic [7:0] e);
      @(posedge sys_clk);
      tx_lin_valid <= 1'b1;
      tx_lin <= s;
      @(posedge sys_clk);
      tx_lin_valid <= 1'b0;
      #1;
      check("tx_pcm_valid", v, tx_pcm_valid);
      if (v)
         check("tx_pcm", e, tx_pcm);
   endtask : tx

   task automatic rx(input logic [7:0] w, input logic pos);
      @(posedge sys_clk);
      send_req <= 1'b1;
      send_word <= w;
      @(posedge sys_clk);
      send_req <= 1'b0;
      @(posedge sys_clk);
      #1;
      check("rx_lin_valid", 1, rx_lin_valid);
      check("rx_lin_sign", pos, rx_lin > 0);
   endtask : rx

   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial
   begin
      #100000;
      errors++;
      close_out();
   end

   initial
   begin
      {arst_n, reg_wr, reg_rd, tx_lin_valid, send_req} = '0;
      {reg_addr, reg_wdata, send_word} = '0;
      {tx_lin, rx_gained} = '0;
      errors = 0;
      comparisons = 0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      check_defaults();
      for (int i = 0; i < 6; i++)
      begin
         rd(ofs[i], rst_val[i]);
         wr(ofs[i], 8'h77);
         rd(ofs[i], 8'h77);
         wr(ofs[i], 8'h00);
      end
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      tx(16'sh7FFF, 1'b0, 8'h00);
      wr(8'h0A, 8'h75);
      check("tx_filter_gain", 7, tx_filter_gain);
      check("rx_filter_gain", 5, rx_filter_gain);
      check("tx_gain_cdb", 700, tx_gain_cdb);
      check("rx_gain_cdb", -500, rx_gain_cdb);
      wr(8'h0B, 8'h07);
      check("sidetone_gain_code", 7, sidetone_gain_code);
      check("st_gain_cdb", 1328, st_gain_cdb);
      wr(8'h0E, 8'h01);
      check("tx_hpf_en", 1, {dial_lpf_en, tx_hpf_en});
      wr(8'h0E, 8'h02);
      check("dial_lpf_en", 2, {dial_lpf_en, tx_hpf_en});
      wr(8'h12, 8'h01);
      wr(8'h13, 8'h00);
      check("powered", 2, {tx_powered, rx_powered});
      // residual stays near zero: each law set is symmetric
      for (int l = 0; l < 3; l++)
      begin
         wr(8'h0F, lawreg[l]);
         for (int k = 0; k < 4; k++)
            tx(smp[k], 1'b1, codes[l][k]);
      end
      wr(8'h13, 8'h02);
      check("powered", 3, {tx_powered, rx_powered});
      check("sidetone_en", 0, sidetone_en);
      for (int l = 0; l < 3; l++)
      begin
         wr(8'h0F, lawreg[l]);
         rx(codes[l][0], 1'b1);
         rx(codes[l][3], 1'b0);
      end
      @(posedge sys_clk);
      rx_gained <= 16'sd100;
      tx_lin <= 16'sd50;
      repeat (2) @(posedge sys_clk);
      #1;
      check("handset_drive", 100, handset_drive);
      wr(8'h13, 8'h01);
      check("sidetone_en", 1, sidetone_en);
      @(posedge sys_clk);
      #1;
      check("handset_drive", 150, handset_drive);
      wr(8'h0A, 8'h03);
      @(posedge sys_clk);
      #1;
      check("handset_drive", 150, handset_drive);
      // second power-up reset in mid-run, every register away from its reset value
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      check_defaults();
      rd(8'h0F, 8'h00);
      rd(8'h0B, 8'h03);
      tx(16'sh7FFF, 1'b0, 8'h00);
      check("handset_drive", 100, handset_drive);
      close_out();
   end
endmodule : vcc_codec_control_test
